// ===== verilog/urx_map.svh
`ifndef URX_MAP_SVH
`define URX_MAP_SVH

`define URX_NUM_EP 4
`define URX_EP_W 2
`define URX_PTR_W 5
`define URX_DEPTH 16

// register indices, byte address is four times the index
`define URX_IDX_FLAGS 8'hE5
`define URX_IDX_CTRL 8'hE6
`define URX_IDX_EPSEL 8'hE7
`define URX_IDX_ISTAT 8'hE8
`define URX_IDX_IMASK 8'hE9
`define URX_IDX_DATA 8'hEA

// control bits
`define URX_CTRL_REV 0
`define URX_CTRL_ADV 1
`define URX_CTRL_ARM 2
`define URX_CTRL_CLR 3

// interrupt status bits
`define URX_IS_OVF 0
`define URX_IS_URF 1
`define URX_IS_ADV 2
`define URX_IS_REV 3

`define URX_FLAGS_RESET 8'h08

`endif

// ===== verilog/urx_pkg.sv
`include "urx_map.svh"

package urx_pkg;

  typedef struct packed {
    logic [`URX_PTR_W-1:0] wp;
    logic [`URX_PTR_W-1:0] wm;
    logic [`URX_PTR_W-1:0] rp;
    logic [1:0] fif;
    logic ovf;
    logic urf;
    logic arm;
    logic clr;
    logic adv;
    logic rev;
  } urx_ep_t;

  typedef struct packed {
    urx_ep_t [`URX_NUM_EP-1:0] ep;
    logic [`URX_EP_W-1:0] epsel;
    logic [3:0] ist;
    logic [3:0] imask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } urx_state_t;

  typedef struct packed {
    logic [7:0] rdata;
  } urx_ram_state_t;

endpackage : urx_pkg

// ===== verilog/urx_ram_if.sv
`timescale 1ns/1ps
`default_nettype none

interface urx_ram_if;
  logic we;
  logic [5:0] waddr;
  logic [7:0] wdata;
  logic [5:0] raddr;
  logic [7:0] rdata;
  modport master (output we, output waddr, output wdata, output raddr, input rdata);
  modport slave (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : urx_ram_if

`default_nettype wire

// ===== verilog/urx_ram.sv
`timescale 1ns/1ps
`default_nettype none

module urx_ram (
  input wire logic pclk,
  input wire logic presetn,
  urx_ram_if.slave bus
);
  logic [7:0] mem [0:63];
  urx_pkg::urx_ram_state_t r;
  urx_pkg::urx_ram_state_t n;

  always_comb begin
    n = r;
    n.rdata = mem[bus.raddr];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // storage array, no reset needed
  always_ff @(posedge pclk) begin
    if (bus.we) begin
      mem[bus.waddr] <= bus.wdata;
    end
  end

  assign bus.rdata = r.rdata;
endmodule : urx_ram

`default_nettype wire

// ===== verilog/urx_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "urx_map.svh"

module urx_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_wr_en,
  input wire logic [1:0] rx_wr_ep,
  input wire logic [7:0] rx_wr_data,
  input wire logic rx_pkt_ok,
  input wire logic rx_pkt_bad,
  output logic irq
);
  urx_pkg::urx_state_t r;
  urx_pkg::urx_state_t n;
  urx_ram_if ram_bus();

  logic ram_we;
  logic [5:0] ram_waddr;
  logic [5:0] ram_raddr;
  logic wr_done;
  logic [7:0] flags_sel;
  logic go_adv0;
  logic go_rev0;

  function automatic logic reg_hit(input logic [11:0] a, input logic [7:0] idx);
    reg_hit = (a == {2'b00, idx, 2'b00});
  endfunction : reg_hit

  function automatic logic ep_full(input urx_pkg::urx_ep_t e);
    ep_full = (e.wp[4] != e.rp[4]) && (e.wp[3:0] == e.rp[3:0]);
  endfunction : ep_full

  function automatic logic ep_empty(input urx_pkg::urx_ep_t e);
    ep_empty = (e.wm == e.rp);
  endfunction : ep_empty

  function automatic logic [1:0] fif_adv(input logic [1:0] f);
    case (f)
      2'h0: fif_adv = 2'h1;
      2'h1: fif_adv = 2'h1;
      2'h2: fif_adv = 2'h3;
      default: fif_adv = f;
    endcase
  endfunction : fif_adv

  function automatic logic [7:0] flag_byte(input urx_pkg::urx_ep_t e);
    flag_byte = {e.fif, 2'b00, ep_empty(e), ep_full(e), e.urf, e.ovf};
  endfunction : flag_byte

  urx_ram u_ram (
    .pclk(pclk),
    .presetn(presetn),
    .bus(ram_bus.slave)
  );

  assign ram_bus.we = ram_we;
  assign ram_bus.waddr = ram_waddr;
  assign ram_bus.wdata = rx_wr_data;
  assign ram_bus.raddr = ram_raddr;

  always_comb begin
    logic [3:0] ev;
    logic [1:0] e;
    logic [1:0] s;
    logic any_hit;
    ev = 4'h0;
    e = rx_wr_ep;
    s = r.epsel;
    any_hit = 1'b0;
    n = r;
    ram_we = 1'b0;
    ram_waddr = 6'h00;
    go_adv0 = 1'b0;
    go_rev0 = 1'b0;
    wr_done = psel && penable && r.pready;
    ram_raddr = {s, r.ep[s].rp[3:0]};
    flags_sel = flag_byte(r.ep[s]);
    for (int i = 0; i < `URX_NUM_EP; i++) begin
      if (r.ep[i].clr) begin
        n.ep[i].wp = 5'h00;
        n.ep[i].wm = 5'h00;
        n.ep[i].rp = 5'h00;
        n.ep[i].fif = 2'h0;
        n.ep[i].ovf = 1'b0;
        n.ep[i].urf = 1'b0;
        n.ep[i].adv = 1'b0;
        n.ep[i].rev = 1'b0;
        n.ep[i].clr = 1'b0;
      end else begin
        if (r.ep[i].adv && !r.ep[i].rev && !r.ep[i].arm) begin
          n.ep[i].wm = r.ep[i].wp;
          n.ep[i].fif = fif_adv(r.ep[i].fif);
          n.ep[i].adv = 1'b0;
          ev[`URX_IS_ADV] = 1'b1;
          if (i == 0) begin
            go_adv0 = 1'b1;
          end
        end
        if (r.ep[i].rev && !r.ep[i].adv && !r.ep[i].arm) begin
          n.ep[i].wp = r.ep[i].wm;
          n.ep[i].rev = 1'b0;
          ev[`URX_IS_REV] = 1'b1;
          if (i == 0) begin
            go_rev0 = 1'b1;
          end
        end
      end
    end
    if (rx_wr_en) begin
      if (ep_full(r.ep[e])) begin
        n.ep[e].ovf = 1'b1;
        ev[`URX_IS_OVF] = 1'b1;
      end else begin
        ram_we = 1'b1;
        ram_waddr = {e, n.ep[e].wp[3:0]};
        n.ep[e].wp = n.ep[e].wp + 5'h01;
      end
    end
    if (r.ep[e].arm && rx_pkt_ok) begin
      n.ep[e].wm = n.ep[e].wp;
      n.ep[e].fif = fif_adv(r.ep[e].fif);
      ev[`URX_IS_ADV] = 1'b1;
    end else if (r.ep[e].arm && rx_pkt_bad) begin
      n.ep[e].wp = n.ep[e].wm;
      ev[`URX_IS_REV] = 1'b1;
    end
    any_hit = reg_hit(paddr, `URX_IDX_FLAGS) || reg_hit(paddr, `URX_IDX_CTRL) ||
              reg_hit(paddr, `URX_IDX_EPSEL) || reg_hit(paddr, `URX_IDX_ISTAT) ||
              reg_hit(paddr, `URX_IDX_IMASK) || reg_hit(paddr, `URX_IDX_DATA);
    n.pready = psel && penable && !r.pready;
    n.pslverr = n.pready && !any_hit;
    if (n.pready && !pwrite) begin
      if (reg_hit(paddr, `URX_IDX_FLAGS)) begin
        n.prdata = {24'h000000, flags_sel};
      end else if (reg_hit(paddr, `URX_IDX_CTRL)) begin
        n.prdata = {28'h0000000, r.ep[s].clr, r.ep[s].arm, r.ep[s].adv, r.ep[s].rev};
      end else if (reg_hit(paddr, `URX_IDX_EPSEL)) begin
        n.prdata = {30'h00000000, r.epsel};
      end else if (reg_hit(paddr, `URX_IDX_ISTAT)) begin
        n.prdata = {28'h0000000, r.ist};
      end else if (reg_hit(paddr, `URX_IDX_IMASK)) begin
        n.prdata = {28'h0000000, r.imask};
      end else if (reg_hit(paddr, `URX_IDX_DATA) && !ep_empty(r.ep[s])) begin
        n.prdata = {24'h000000, ram_bus.rdata};
      end else begin
        n.prdata = 32'h00000000;
      end
    end else if (n.pready) begin
      n.prdata = 32'h00000000;
    end
    if (wr_done && !pwrite && reg_hit(paddr, `URX_IDX_DATA)) begin
      if (ep_empty(r.ep[s])) begin
        n.ep[s].urf = 1'b1;
        ev[`URX_IS_URF] = 1'b1;
      end else begin
        n.ep[s].rp = r.ep[s].rp + 5'h01;
      end
    end
    n.ist = r.ist;
    if (wr_done && pwrite) begin
      if (reg_hit(paddr, `URX_IDX_CTRL)) begin
        n.ep[s].arm = pwdata[`URX_CTRL_ARM];
        n.ep[s].clr = pwdata[`URX_CTRL_CLR];
        if (!pwdata[`URX_CTRL_ARM]) begin
          n.ep[s].adv = pwdata[`URX_CTRL_ADV];
          n.ep[s].rev = pwdata[`URX_CTRL_REV];
        end
      end else if (reg_hit(paddr, `URX_IDX_EPSEL)) begin
        n.epsel = pwdata[1:0];
      end else if (reg_hit(paddr, `URX_IDX_ISTAT)) begin
        n.ist = r.ist & ~pwdata[3:0];
      end else if (reg_hit(paddr, `URX_IDX_IMASK)) begin
        n.imask = pwdata[3:0];
      end
    end
    n.ist = n.ist | ev;
    n.irq = |(n.ist & n.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign irq = r.irq;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic wr_ctrl;
  assign wr_ctrl = wr_done && pwrite && reg_hit(paddr, `URX_IDX_CTRL);

  property p_adv_moves;
    r.ep[0].adv && !r.ep[0].rev && !r.ep[0].arm && !r.ep[0].clr && !rx_wr_en && !wr_ctrl
      |=> r.ep[0].wm == $past(r.ep[0].wp) && !r.ep[0].adv;
  endproperty
  a_adv_moves: assert property (p_adv_moves) else $error("advance did not move marker");

  property p_adv_blocked;
    r.ep[0].adv && r.ep[0].rev && !r.ep[0].arm && !r.ep[0].clr && !rx_wr_en
      |=> $stable(r.ep[0].wm) && $stable(r.ep[0].wp);
  endproperty
  a_adv_blocked: assert property (p_adv_blocked) else $error("blocked command acted");

  property p_rev_moves;
    r.ep[0].rev && !r.ep[0].adv && !r.ep[0].arm && !r.ep[0].clr && !rx_wr_en && !wr_ctrl
      |=> r.ep[0].wp == $past(r.ep[0].wm) && !r.ep[0].rev;
  endproperty
  a_rev_moves: assert property (p_rev_moves) else $error("rewind did not restore pointer");

  property p_rewrite_origin;
    (go_rev0 && !rx_wr_en && !wr_ctrl) ##1 (ram_we && rx_wr_ep == 2'h0)
      |-> ram_waddr[3:0] == $past(r.ep[0].wm[3:0]);
  endproperty
  a_rewrite_origin: assert property (p_rewrite_origin) else $error("rewrite not at origin");

  property p_rev_blocked;
    r.ep[0].rev && r.ep[0].arm && !r.ep[0].clr && !rx_wr_en && !rx_pkt_bad |=> $stable(r.ep[0].wp);
  endproperty
  a_rev_blocked: assert property (p_rev_blocked) else $error("rewind acted in auto mode");

  property p_flags_read;
    psel && penable && !r.pready && !pwrite && reg_hit(paddr, `URX_IDX_FLAGS)
      |=> pready && prdata == {24'h000000, $past(flags_sel)} && prdata[5:4] == 2'h0;
  endproperty
  a_flags_read: assert property (p_flags_read) else $error("flag read mismatch");

  property p_auto_ignores;
    wr_ctrl && pwdata[`URX_CTRL_ARM] && !r.ep[r.epsel].adv && !r.ep[r.epsel].rev
      |=> !r.ep[$past(r.epsel)].adv && !r.ep[$past(r.epsel)].rev;
  endproperty
  a_auto_ignores: assert property (p_auto_ignores) else $error("command taken in auto mode");

  property p_indexed_write;
    wr_ctrl && pwdata[`URX_CTRL_ADV] && !pwdata[`URX_CTRL_ARM] && !pwdata[`URX_CTRL_CLR] &&
      !pwdata[`URX_CTRL_REV]
      |=> r.ep[$past(r.epsel)].adv ##1 !r.ep[$past(r.epsel, 2)].adv;
  endproperty
  a_indexed_write: assert property (p_indexed_write) else $error("control write misplaced");

  property p_pready_pulse;
    pready |=> !pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("pready held too long");

  c_adv: cover property (go_adv0);
  c_rev_rewrite: cover property (go_rev0 ##[1:20] ram_we);
  c_overflow: cover property (rx_wr_en && ep_full(r.ep[rx_wr_ep]));
  c_irq: cover property (!irq ##1 irq);
endmodule : urx_top

`default_nettype wire

// ===== tb/urx_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module urx_host_model (
  input wire logic pclk,
  output logic wr_en,
  output logic [1:0] wr_ep,
  output logic [7:0] wr_data,
  output logic pkt_ok,
  output logic pkt_bad
);
  initial begin
    wr_en = 1'b0;
    wr_ep = 2'h0;
    wr_data = 8'hA5;
    pkt_ok = 1'b0;
    pkt_bad = 1'b0;
  end

  task automatic send(input logic [1:0] ep, input int n, input logic [7:0] base,
                      input logic [1:0] kind);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      wr_en <= 1'b1;
      wr_ep <= ep;
      wr_data <= base + 8'(i);
      pkt_ok <= (i == n - 1) && kind[0];
      pkt_bad <= (i == n - 1) && kind[1];
    end
    @(posedge pclk);
    wr_en <= 1'b0;
    wr_data <= ~wr_data;
    pkt_ok <= 1'b0;
    pkt_bad <= 1'b0;
  endtask : send
endmodule : urx_host_model

`default_nettype wire

// ===== tb/usb_rx_fifo_pointer_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "urx_map.svh"

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end

module usb_rx_fifo_pointer_control_tb_top;
  localparam logic [7:0] FL = `URX_IDX_FLAGS;
  localparam logic [7:0] CT = `URX_IDX_CTRL;
  localparam logic [7:0] EP = `URX_IDX_EPSEL;
  localparam logic [7:0] ST = `URX_IDX_ISTAT;
  localparam logic [7:0] MK = `URX_IDX_IMASK;
  localparam logic [7:0] DA = `URX_IDX_DATA;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rx_wr_en, rx_pkt_ok, rx_pkt_bad;
  logic [1:0] rx_wr_ep;
  logic [7:0] rx_wr_data;
  int fail_count = 0;
  int n_compared = 0;

  urx_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_wr_en(rx_wr_en), .rx_wr_ep(rx_wr_ep),
    .rx_wr_data(rx_wr_data), .rx_pkt_ok(rx_pkt_ok), .rx_pkt_bad(rx_pkt_bad), .irq(irq));

  urx_host_model host (.pclk(pclk), .wr_en(rx_wr_en), .wr_ep(rx_wr_ep),
    .wr_data(rx_wr_data), .pkt_ok(rx_pkt_ok), .pkt_bad(rx_pkt_bad));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic wrap_up();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : wrap_up

  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      fail_count++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    `CHK(rd, exp)
  endtask : rdchk

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(FL, 32'h08);
    rdchk(CT, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    `CHK({31'h0, err}, 32'h1)
    apb(1'b1, MK, 32'h4);
    host.send(2'h0, 4, 8'h10, 2'h0);
    rdchk(FL, 32'h08);
    apb(1'b1, CT, 32'h2);
    rdchk(CT, 32'h0);
    rdchk(FL, 32'h40);
    `CHK({31'h0, irq}, 32'h1)
    apb(1'b1, ST, 32'h4);
    @(posedge pclk);
    `CHK({31'h0, irq}, 32'h0)
    for (int i = 0; i < 4; i++) rdchk(DA, 32'h10 + 32'(i));
    host.send(2'h0, 3, 8'h20, 2'h0);
    apb(1'b1, CT, 32'h1);
    host.send(2'h0, 3, 8'h30, 2'h0);
    rdchk(CT, 32'h0);
    apb(1'b1, CT, 32'h2);
    for (int i = 0; i < 3; i++) rdchk(DA, 32'h30 + 32'(i));
    apb(1'b1, CT, 32'h3);
    rdchk(CT, 32'h3);
    host.send(2'h0, 2, 8'h40, 2'h0);
    apb(1'b0, FL, 32'h0);
    `CHK(rd & 32'h8, 32'h8)
    apb(1'b1, CT, 32'h7);
    rdchk(CT, 32'h7);
    apb(1'b1, CT, 32'h8);
    rdchk(CT, 32'h0);
    apb(1'b1, CT, 32'h4);
    apb(1'b1, CT, 32'h6);
    rdchk(CT, 32'h4);
    host.send(2'h0, 2, 8'h50, 2'h1);
    rdchk(DA, 32'h50);
    rdchk(DA, 32'h51);
    host.send(2'h0, 2, 8'h60, 2'h2);
    rdchk(DA, 32'h0);
    rdchk(ST, 32'hE);
    rdchk(FL, 32'h4A);
    apb(1'b1, CT, 32'h0);
    apb(1'b1, EP, 32'h1);
    host.send(2'h1, 2, 8'h70, 2'h0);
    apb(1'b1, CT, 32'h2);
    apb(1'b0, FL, 32'h0);
    `CHK(rd & 32'h8, 32'h0)
    apb(1'b1, EP, 32'h0);
    apb(1'b0, FL, 32'h0);
    `CHK(rd & 32'h8, 32'h8)
    apb(1'b1, EP, 32'h1);
    rdchk(DA, 32'h70);
    host.send(2'h1, 16, 8'h80, 2'h0);
    rdchk(FL, 32'h45);
    rdchk(ST, 32'hF);
    wrap_up();
  end
endmodule : usb_rx_fifo_pointer_control_tb_top

`default_nettype wire
